// >>> timer16_pkg.sv
// constants, field layouts and register map of the 16-bit timer mode and flag block

package timer16_pkg;

    // =========================================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    // =========================================================
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE_CTRL   = 8'h31;
    localparam logic [IDX_W-1:0] IDX_CTRL1       = 8'h32;
    localparam logic [IDX_W-1:0] IDX_FLAGS       = 8'h33;
    localparam logic [IDX_W-1:0] IDX_CAP1_HI     = 8'h34;
    localparam logic [IDX_W-1:0] IDX_CAP1_LO     = 8'h35;
    localparam logic [IDX_W-1:0] IDX_CMP1_HI     = 8'h36;
    localparam logic [IDX_W-1:0] IDX_CMP1_LO     = 8'h37;
    localparam logic [IDX_W-1:0] IDX_CNT_HI      = 8'h38;
    localparam logic [IDX_W-1:0] IDX_CNT_LO      = 8'h39;
    localparam logic [IDX_W-1:0] IDX_ALT_CNT_HI  = 8'h3a;
    localparam logic [IDX_W-1:0] IDX_ALT_CNT_LO  = 8'h3b;
    localparam logic [IDX_W-1:0] IDX_CAP2_HI     = 8'h3c;
    localparam logic [IDX_W-1:0] IDX_CAP2_LO     = 8'h3d;
    localparam logic [IDX_W-1:0] IDX_CMP2_HI     = 8'h3e;
    localparam logic [IDX_W-1:0] IDX_CMP2_LO     = 8'h3f;

    // =========================================================
    // reset values and counter top
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    localparam logic [7:0]  CTRL1_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET   = 16'hfffc;
    localparam logic [15:0] CNT_TOP     = 16'hffff;
    localparam logic [15:0] CMP_RESET   = 16'h8000;
    localparam logic [15:0] CAP_RESET   = 16'h0000;

    // =========================================================
    // status layout: five flags in bits 7:3, freeze in bit 2
    localparam int FLAG_N      = 5;
    localparam int FLAG_LSB    = 3;
    localparam int FREEZE_BIT  = 2;
    localparam int FL_CMP2     = 0;
    localparam int FL_CAP2     = 1;
    localparam int FL_OVF      = 2;
    localparam int FL_CMP1     = 3;
    localparam int FL_CAP1     = 4;

    // =========================================================
    // clock source codes and prescaler terminal counts
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT  = 2'h3;
    localparam int         PRE_W    = 3;
    localparam logic [PRE_W-1:0] PRE_TERM_DIV4 = 3'h3;
    localparam logic [PRE_W-1:0] PRE_TERM_DIV2 = 3'h1;
    localparam logic [PRE_W-1:0] PRE_TERM_DIV8 = 3'h7;

    // =========================================================
    // register layouts, msb first
    typedef struct packed {
        logic       cmp1_pin_enable;
        logic       cmp2_pin_enable;
        logic       single_pulse_select;
        logic       pwm_select;
        logic [1:0] clock_source_field;
        logic       cap2_edge_select;
        logic       ext_clock_edge_select;
    } mode_ctrl_type;

    typedef struct packed {
        logic cap_irq_enable;
        logic cmp_irq_enable;
        logic ovf_irq_enable;
        logic force_cmp2;
        logic force_cmp1;
        logic cmp2_level;
        logic cap1_edge_select;
        logic cmp1_level;
    } ctrl1_type;

endpackage

// >>> pin_edge_sync.sv
// three-stage pin synchroniser with selectable edge detector
`timescale 1ns/10ps

module pin_edge_sync (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic pin_in,
    input  wire logic rising_sel,
    output logic      edge_pulse
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic stable_ff;
    logic agree;

    // =========================================================
    // synchroniser; a change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else if (clk_en) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign agree = (s2_ff == s3_ff);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stable_ff <= 1'b0;
        end else if (clk_en && agree) begin
            stable_ff <= s3_ff;
        end
    end

    // =========================================================
    // one pulse per qualified transition of the chosen polarity
    assign edge_pulse = clk_en && agree && (s3_ff != stable_ff) && (s3_ff == rising_sel);

endmodule

// >>> timer16_mode_and_status_control.sv
// 16-bit timer: clock selection, modes, compare pins, flags and apb registers
`timescale 1ns/10ps

module timer16_mode_and_status_control
    import timer16_pkg::*;
#(
    parameter bit HAS_EXT_PIN = 1'b1
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              cap1_in_pin,
    input  wire logic              cap2_in_pin,
    input  wire logic              ext_count_pin,
    output logic                   cmp1_out_pin,
    output logic                   cmp1_out_en,
    output logic                   cmp2_out_pin,
    output logic                   cmp2_out_en,
    output logic                   timer_irq
);

    // =========================================================
    // state
    mode_ctrl_type          mode_ff;
    ctrl1_type              ctrl1_ff;
    logic                   freeze_ff;
    logic [FLAG_N-1:0]      flag_ff;
    logic [FLAG_N-1:0]      arm_ff;
    logic [15:0]            cnt_ff;
    logic [15:0]            cap1_ff;
    logic [15:0]            cap2_ff;
    logic [15:0]            cmp1_ff;
    logic [15:0]            cmp2_ff;
    logic [PRE_W-1:0]       pre_ff;
    logic                   lvl1_ff;
    logic                   lvl2_ff;
    logic                   irq_ff;
    logic [DATA_W-1:0]      rdata_ff;
    logic                   slverr_ff;

    // =========================================================
    // combinational signals
    logic [IDX_W-1:0]       reg_idx;
    logic                   addr_ok;
    logic                   setup_ph;
    logic                   acc_done;
    logic                   wr_acc;
    logic                   rd_acc;
    logic                   status_rd;
    logic                   cnt_lo_wr;
    logic [PRE_W-1:0]       pre_term;
    logic                   pre_tick;
    logic                   ext_allowed;
    logic                   tick;
    logic                   cap1_edge;
    logic                   cap2_edge;
    logic                   ext_edge;
    logic                   cmp1_match;
    logic                   cmp2_match;
    logic                   pwm_restart;
    logic                   pulse_start;
    logic                   wrap;
    logic [FLAG_N-1:0]      flag_set;
    logic [FLAG_N-1:0]      flag_clr_acc;
    logic [7:0]             status_byte;
    logic [7:0]             rd_byte;
    logic                   rd_hit;
    logic [7:0]             wbyte;
    ctrl1_type              wr_ctrl1;

    // =========================================================
    // pin inputs
    pin_edge_sync cap1_sync (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .clk_en     (clk_en),
        .pin_in     (cap1_in_pin),
        .rising_sel (ctrl1_ff.cap1_edge_select),
        .edge_pulse (cap1_edge)
    );

    pin_edge_sync cap2_sync (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .clk_en     (clk_en),
        .pin_in     (cap2_in_pin),
        .rising_sel (mode_ff.cap2_edge_select),
        .edge_pulse (cap2_edge)
    );

    pin_edge_sync ext_sync (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .clk_en     (clk_en),
        .pin_in     (ext_count_pin),
        .rising_sel (mode_ff.ext_clock_edge_select),
        .edge_pulse (ext_edge)
    );

    // =========================================================
    // apb decode; one access cycle, no wait states while enabled
    assign reg_idx  = paddr[IDX_W+1:2];
    assign wbyte    = pwdata[7:0];
    assign wr_ctrl1 = ctrl1_type'(wbyte);
    assign setup_ph = psel && !penable;
    assign acc_done = psel && penable && clk_en;
    assign wr_acc   = acc_done && pwrite;
    assign rd_acc   = acc_done && !pwrite;
    assign pready   = clk_en;
    assign prdata   = rdata_ff;
    assign pslverr  = slverr_ff;

    always_comb begin
        addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == '0)
                  && (reg_idx >= IDX_MODE_CTRL) && (reg_idx <= IDX_CMP2_LO);
    end

    // bus accesses stay live while frozen
    assign status_rd = rd_acc && addr_ok && (reg_idx == IDX_FLAGS);
    assign cnt_lo_wr = wr_acc && addr_ok
                       && (reg_idx == IDX_CNT_LO || reg_idx == IDX_ALT_CNT_LO);

    // =========================================================
    // prescaler and timer tick
    always_comb begin
        unique case (mode_ff.clock_source_field)
            CLK_DIV2: pre_term = PRE_TERM_DIV2;
            CLK_DIV8: pre_term = PRE_TERM_DIV8;
            default:  pre_term = PRE_TERM_DIV4;
        endcase
    end

    assign pre_tick    = (pre_ff >= pre_term);
    assign ext_allowed = HAS_EXT_PIN;

    always_comb begin
        if (freeze_ff) begin
            tick = 1'b0;
        end else if (mode_ff.clock_source_field == CLK_EXT) begin
            tick = ext_allowed && ext_edge;
        end else begin
            tick = clk_en && pre_tick;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pre_ff <= '0;
        end else if (clk_en) begin
            // pulse start restarts the phase so a single pulse has an exact width
            if (cnt_lo_wr || pulse_start || (pre_tick && !freeze_ff)) begin
                pre_ff <= '0;
            end else if (!freeze_ff) begin
                pre_ff <= pre_ff + 1'b1;
            end
        end
    end

    // =========================================================
    // counter and mode events
    // compare logic is independent of the pin enables
    assign cmp1_match  = tick && (cnt_ff == cmp1_ff);
    assign cmp2_match  = tick && (cnt_ff == cmp2_ff);
    assign pwm_restart = mode_ff.pwm_select && cmp2_match;
    assign pulse_start = mode_ff.single_pulse_select && !mode_ff.pwm_select
                         && cap1_edge && !freeze_ff;
    assign wrap        = tick && (cnt_ff == CNT_TOP) && !pwm_restart;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_ff <= CNT_RESET;
        end else if (clk_en) begin
            if (cnt_lo_wr) begin
                cnt_ff <= CNT_RESET;
            end else if (pwm_restart || pulse_start) begin
                cnt_ff <= CNT_RESET;
            end else if (tick) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    // =========================================================
    // input captures
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cap1_ff <= CAP_RESET;
            cap2_ff <= CAP_RESET;
        end else if (clk_en) begin
            if (cap1_edge) begin
                cap1_ff <= cnt_ff;
            end
            if (cap2_edge) begin
                cap2_ff <= cnt_ff;
            end
        end
    end

    // =========================================================
    // compare output levels
    // pulse modes: level 2 at period start, level 1 at compare-1 match
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lvl1_ff <= 1'b0;
            lvl2_ff <= 1'b0;
        end else if (clk_en) begin
            if (mode_ff.pwm_select || mode_ff.single_pulse_select) begin
                if (pwm_restart || pulse_start) begin
                    lvl1_ff <= ctrl1_ff.cmp2_level;
                end else if (cmp1_match) begin
                    lvl1_ff <= ctrl1_ff.cmp1_level;
                end
            end else if (cmp1_match) begin
                lvl1_ff <= ctrl1_ff.cmp1_level;
            end
            if (cmp2_match && !mode_ff.pwm_select) begin
                lvl2_ff <= ctrl1_ff.cmp2_level;
            end
            if (wr_acc && addr_ok && reg_idx == IDX_CTRL1) begin
                if (wr_ctrl1.force_cmp1) begin
                    lvl1_ff <= wr_ctrl1.cmp1_level;
                end
                if (wr_ctrl1.force_cmp2) begin
                    lvl2_ff <= wr_ctrl1.cmp2_level;
                end
            end
        end
    end

    // pins released to general-purpose use when disabled or frozen
    assign cmp1_out_pin = lvl1_ff;
    assign cmp2_out_pin = lvl2_ff;
    assign cmp1_out_en  = mode_ff.cmp1_pin_enable && !freeze_ff;
    assign cmp2_out_en  = mode_ff.cmp2_pin_enable && !freeze_ff;

    // =========================================================
    // software registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_ff   <= mode_ctrl_type'(MODE_RESET);
            ctrl1_ff  <= ctrl1_type'(CTRL1_RESET);
            freeze_ff <= 1'b0;
            cmp1_ff   <= CMP_RESET;
            cmp2_ff   <= CMP_RESET;
        end else if (clk_en && wr_acc && addr_ok) begin
            unique case (reg_idx)
                IDX_MODE_CTRL: mode_ff   <= mode_ctrl_type'(wbyte);
                IDX_CTRL1:     ctrl1_ff  <= ctrl1_type'(wbyte);
                // only the freeze bit of the status byte is writable
                IDX_FLAGS:     freeze_ff <= wbyte[FREEZE_BIT];
                IDX_CMP1_HI:   cmp1_ff[15:8] <= wbyte;
                IDX_CMP1_LO:   cmp1_ff[7:0]  <= wbyte;
                IDX_CMP2_HI:   cmp2_ff[15:8] <= wbyte;
                IDX_CMP2_LO:   cmp2_ff[7:0]  <= wbyte;
                default: ;
            endcase
        end
    end

    // =========================================================
    // event flags
    always_comb begin
        flag_set          = '0;
        flag_set[FL_CAP1] = cap1_edge || pwm_restart;
        flag_set[FL_CMP1] = cmp1_match;
        flag_set[FL_OVF]  = wrap;
        flag_set[FL_CAP2] = cap2_edge;
        flag_set[FL_CMP2] = cmp2_match;
    end

    // either access direction to the low byte qualifies
    always_comb begin
        flag_clr_acc          = '0;
        flag_clr_acc[FL_CAP1] = acc_done && addr_ok && reg_idx == IDX_CAP1_LO;
        flag_clr_acc[FL_CMP1] = acc_done && addr_ok && reg_idx == IDX_CMP1_LO;
        flag_clr_acc[FL_OVF]  = acc_done && addr_ok && reg_idx == IDX_CNT_LO;
        flag_clr_acc[FL_CAP2] = acc_done && addr_ok && reg_idx == IDX_CAP2_LO;
        flag_clr_acc[FL_CMP2] = acc_done && addr_ok && reg_idx == IDX_CMP2_LO;
    end

    // a new event in the clearing cycle keeps the flag set
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    flag_ff[gi] <= 1'b0;
                    arm_ff[gi]  <= 1'b0;
                end else if (clk_en) begin
                    flag_ff[gi] <= flag_set[gi]
                                   || (flag_ff[gi] && !(arm_ff[gi] && flag_clr_acc[gi]));
                    if (arm_ff[gi] && flag_clr_acc[gi]) begin
                        arm_ff[gi] <= 1'b0;
                    end else if (status_rd && flag_ff[gi]) begin
                        arm_ff[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // interrupt request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= (ctrl1_ff.cap_irq_enable && (flag_ff[FL_CAP1] || flag_ff[FL_CAP2]))
                   || (ctrl1_ff.cmp_irq_enable && (flag_ff[FL_CMP1] || flag_ff[FL_CMP2]))
                   || (ctrl1_ff.ovf_irq_enable && flag_ff[FL_OVF]);
        end
    end

    assign timer_irq = irq_ff;

    // =========================================================
    // read path, sampled in the setup cycle
    assign status_byte = {flag_ff, freeze_ff, 2'h0};

    always_comb begin
        rd_hit = 1'b1;
        unique case (reg_idx)
            IDX_MODE_CTRL:  rd_byte = mode_ff;
            IDX_CTRL1:      rd_byte = ctrl1_ff;
            IDX_FLAGS:      rd_byte = status_byte;
            IDX_CAP1_HI:    rd_byte = cap1_ff[15:8];
            IDX_CAP1_LO:    rd_byte = cap1_ff[7:0];
            IDX_CMP1_HI:    rd_byte = cmp1_ff[15:8];
            IDX_CMP1_LO:    rd_byte = cmp1_ff[7:0];
            IDX_CNT_HI:     rd_byte = cnt_ff[15:8];
            IDX_CNT_LO:     rd_byte = cnt_ff[7:0];
            IDX_ALT_CNT_HI: rd_byte = cnt_ff[15:8];
            IDX_ALT_CNT_LO: rd_byte = cnt_ff[7:0];
            IDX_CAP2_HI:    rd_byte = cap2_ff[15:8];
            IDX_CAP2_LO:    rd_byte = cap2_ff[7:0];
            IDX_CMP2_HI:    rd_byte = cmp2_ff[15:8];
            IDX_CMP2_LO:    rd_byte = cmp2_ff[7:0];
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff  <= '0;
            slverr_ff <= 1'b0;
        end else if (clk_en && setup_ph) begin
            rdata_ff  <= (addr_ok && rd_hit && !pwrite) ? {24'h00_0000, rd_byte} : '0;
            slverr_ff <= !(addr_ok && rd_hit);
        end
    end

endmodule

// >>> timer16_mode_and_status_control_props.sv
// port assertions for the timer mode and flag block
`timescale 1ns/10ps
module timer16_mode_and_status_control_props
    import timer16_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              cmp1_out_en,
    input wire logic              cmp2_out_en,
    input wire logic              timer_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ========
    // helpers: irq enables tracked from ctrl1 writes, reset leaves them off
    logic acc;
    logic irq_off_ff;
    assign acc = psel && penable && pready;
    always_ff @(posedge ref_clk) begin
        if (reset) irq_off_ff <= 1'b1;
        else if (acc && pwrite && paddr == 12'h0c8) irq_off_ff <= pwdata[7:5] == 3'h0;
    end
    sequence s_wr(logic [11:0] a);
        acc && pwrite && paddr == a;
    endsequence
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    // ========
    // properties
    property p_ready; pready == clk_en; endproperty
    a_ready: assert property (p_ready) else $error("pready differs from clk_en");
    property p_en1_off; s_wr(12'h0c4) ##0 !pwdata[7] |=> !cmp1_out_en; endproperty
    a_en1_off: assert property (p_en1_off) else $error("cmp1 pin still driven");
    property p_en2_off; s_wr(12'h0c4) ##0 !pwdata[6] |=> !cmp2_out_en; endproperty
    a_en2_off: assert property (p_en2_off) else $error("cmp2 pin still driven");
    property p_freeze; s_wr(12'h0cc) ##0 pwdata[2] |=> !cmp1_out_en && !cmp2_out_en; endproperty
    a_freeze: assert property (p_freeze) else $error("pins driven while frozen");
    property p_mapped;
        s_setup ##0 paddr inside {[12'h0c4:12'h0fc]} && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_unmapped; s_setup ##0 paddr < 12'h0c4 |=> pslverr && prdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_status;
        s_setup ##0 !pwrite && paddr == 12'h0cc |=> prdata[1:0] == 2'h0 && prdata[31:8] == '0;
    endproperty
    a_status: assert property (p_status) else $error("status reserved bits set");
    property p_irq; irq_off_ff && $past(irq_off_ff) |-> !timer_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq with all enables off");
endmodule

// >>> timer16_pin_model.sv
// capture and external count pins, changed one at a time on request
`timescale 1ns/10ps
module timer16_pin_model (
    input  wire logic ref_clk,
    output logic      cap1_in_pin,
    output logic      cap2_in_pin,
    output logic      ext_count_pin
);
    logic [2:0] lvl_ff = 3'h0;
    assign {ext_count_pin, cap2_in_pin, cap1_in_pin} = lvl_ff;
    // held long enough for the three-stage sync and the flag to land
    task automatic flip(input int k);
        @(posedge ref_clk) lvl_ff[k] <= !lvl_ff[k];
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// >>> timer16_mode_and_status_control_test.sv
// self-checking bench for the timer mode, flag and register block
`timescale 1ns/10ps
module timer16_mode_and_status_control_test;
    import timer16_pkg::*;
    logic              ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, serr, h;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic              cap1_in_pin, cap2_in_pin, ext_count_pin, cmp1_out_pin, cmp2_out_pin;
    logic              cmp1_out_en, cmp2_out_en, timer_irq;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic [7:0]        rd, st;
    logic [31:0]       seed = 32'h0819_31c0;
    int                errors = 0, compares = 0, hi_cnt = 0, n0;
    timer16_mode_and_status_control i_dut (.*);
    timer16_pin_model i_pins (.ref_clk, .cap1_in_pin, .cap2_in_pin, .ext_count_pin);
    always #25 ref_clk = !ref_clk;
    // high time of compare pin 1, sampled away from the launching edge
    always @(negedge ref_clk) hi_cnt <= hi_cnt + cmp1_out_pin;
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end
    // ========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] ticks(input logic [1:0] f, input int n);
        return 8'(n / (f == CLK_DIV2 ? 2 : f == CLK_DIV8 ? 8 : 4));
    endfunction
    function automatic logic hit(input logic sel, input logic lvl);
        return lvl == sel;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ========
    // scenarios
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        bus(1'b0, 12'h040, 8'h00);
        chk("unmapped", 8'h01, {7'h00, serr});
        bus(1'b1, 12'h0cc, 8'h04);
        bus(1'b0, 12'h0cc, 8'h00);
        bus(1'b1, 12'h0e4, 8'h5a);
        bus(1'b1, 12'h0cc, 8'hfc);
        bus(1'b0, 12'h0cc, 8'h00);
        chk("status", 8'h04, rd);
        repeat (40) @(posedge ref_clk);
        bus(1'b0, 12'h0e4, 8'h00);
        chk("frozen count", 8'hfc, rd);
        bus(1'b1, 12'h0c4, 8'hc0);
        #1 chk("frozen pins", 8'h00, {6'h00, cmp1_out_en, cmp2_out_en});
        bus(1'b1, 12'h0cc, 8'h00);
        #1 chk("pins", 8'h03, {6'h00, cmp1_out_en, cmp2_out_en});
        $display("test done: freeze");
        for (int f = 0; f < 3; f++) begin
            bus(1'b1, 12'h0cc, 8'h04);
            bus(1'b1, 12'h0c4, {4'h0, f[1:0], 2'h0});
            bus(1'b1, 12'h0e4, 8'h00);
            bus(1'b1, 12'h0cc, 8'h00);
            repeat (64) @(posedge ref_clk);
            bus(1'b0, 12'h0e4, 8'h00);
            st = rd - (8'hfc + ticks(f[1:0], 64));
            // prescaler phase at the read leaves up to two ticks of slack
            chk("count rate", 8'h00, st > 8'h02 ? st : 8'h00);
        end
        for (int e = 1; e >= 0; e--) begin
            bus(1'b1, 12'h0c4, {6'h03, 1'b0, e[0]});
            bus(1'b1, 12'h0e4, 8'h00);
            i_pins.flip(2);
            bus(1'b0, 12'h0e4, 8'h00);
            chk("ext count", 8'hfd, rd);
        end
        $display("test done: clock sources");
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 4; e++) begin
                bus(1'b1, 12'h0c8, {6'h20, e[1] & !p[0], 1'b0});
                bus(1'b1, 12'h0c4, {6'h00, e[1] & p[0], 1'b0});
                i_pins.flip(p);
                h = hit(e[1], e[0] == 0);
                bus(1'b0, 12'h0cc, 8'h00);
                st = p ? 8'h10 : 8'h80;
                chk("capture flag", h ? st : 8'h00, rd & st);
                #1 chk("irq", {7'h00, h}, {7'h00, timer_irq});
                bus(1'b0, p ? 12'h0f4 : 12'h0d4, 8'h00);
                bus(1'b0, 12'h0cc, 8'h00);
                chk("flag cleared", 8'h00, rd & st);
            end
        end
        $display("test done: captures");
        seed = xs(seed);
        bus(1'b1, 12'h0cc, 8'h04);
        bus(1'b1, 12'h0c4, 8'h00);
        bus(1'b1, 12'h0d8, 8'h00);
        bus(1'b1, 12'h0dc, seed[7:0]);
        bus(1'b1, 12'h0f8, 8'h00);
        bus(1'b1, 12'h0fc, 8'hff);
        bus(1'b1, 12'h0e4, 8'h00);
        bus(1'b1, 12'h0cc, 8'h00);
        repeat (1100) @(posedge ref_clk);
        bus(1'b1, 12'h0cc, 8'h04);
        bus(1'b0, 12'h0cc, 8'h00);
        chk("match flags", 8'h68, rd & 8'h68);
        bus(1'b0, 12'h0ec, 8'h00);
        bus(1'b0, 12'h0cc, 8'h00);
        chk("overflow kept", 8'h20, rd & 8'h20);
        bus(1'b0, 12'h0dc, 8'h00);
        bus(1'b1, 12'h0fc, seed[15:8]);
        bus(1'b0, 12'h0e4, 8'h00);
        bus(1'b0, 12'h0cc, 8'h00);
        chk("flags cleared", 8'h04, rd);
        $display("test done: compares");
        bus(1'b1, 12'h0c8, 8'h06);
        bus(1'b1, 12'h0d8, 8'hff);
        bus(1'b1, 12'h0dc, 8'hfd);
        bus(1'b1, 12'h0f8, 8'h00);
        bus(1'b1, 12'h0fc, 8'h01);
        bus(1'b1, 12'h0c4, 8'ha0);
        bus(1'b1, 12'h0cc, 8'h00);
        n0 = hi_cnt;
        i_pins.flip(0);
        repeat (16) @(posedge ref_clk);
        chk("single pulse", 8'h08, 8'(hi_cnt - n0));
        bus(1'b0, 12'h0cc, 8'h00);
        bus(1'b0, 12'h0d4, 8'h00);
        #1 chk("cmp2 level", 8'h01, {7'h00, cmp2_out_pin});
        bus(1'b1, 12'h0c4, 8'h90);
        bus(1'b1, 12'h0e4, 8'h00);
        repeat (48) @(posedge ref_clk);
        n0 = hi_cnt;
        repeat (240) @(posedge ref_clk);
        chk("pwm high", 8'h50, 8'(hi_cnt - n0));
        bus(1'b0, 12'h0cc, 8'h00);
        chk("pwm period flag", 8'h80, rd & 8'h80);
        $display("test done: pulse modes");
        print_verdict();
    end
endmodule
bind timer16_mode_and_status_control timer16_mode_and_status_control_props i_props (.*);
